// File: design/stg_pkg.sv
// package of constants and types for the sdi test signal generator
package stg_pkg;
  // register word indices, byte address is four times the index
  localparam logic [3:0] STG_REG_CTRL = 4'h0;
  localparam logic [3:0] STG_REG_TIMING = 4'h1;
  localparam logic [3:0] STG_REG_OFFSET = 4'h2;
  localparam logic [3:0] STG_REG_AVD = 4'h3;
  localparam logic [3:0] STG_REG_CLIP = 4'h4;
  localparam logic [3:0] STG_REG_STATUS = 4'h5;
  localparam logic [3:0] STG_REG_MISC = 4'h6;
  localparam logic [3:0] STG_REG_COLOR = 4'h7;
  // control field positions
  localparam int STG_CTRL_PAT = 0;
  localparam int STG_CTRL_DUAL = 3;
  localparam int STG_CTRL_STD = 4;
  localparam int STG_CTRL_EDH = 6;
  localparam int STG_CTRL_ERR = 7;
  localparam int STG_CTRL_SWL = 8;
  localparam int STG_CTRL_PID = 9;
  localparam int STG_CTRL_IDENT = 12;
  localparam int STG_CTRL_BOX = 13;
  localparam int STG_CTRL_SRC = 14;
  localparam int STG_CTRL_REL = 16;
  // reset values
  localparam logic [11:0] STG_RST_H_TOTAL = 12'h898;
  localparam logic [11:0] STG_RST_V_TOTAL = 12'h465;
  localparam logic [11:0] STG_RST_SW_LINE = 12'h007;
  localparam logic [3:0] STG_RST_RATIO = 4'h1;
  // stress pattern figures and last bit of a serial word
  localparam logic [4:0] STG_EQ_ZEROS = 5'h13;
  localparam logic [1:0] STG_PLL_RUN = 2'h2;
  localparam logic [3:0] STG_WORD_LAST = 4'h9;
  // fixed lines for packets, checksum error line in hd
  localparam logic [11:0] STG_EDH_LINE = 12'h009;
  localparam logic [11:0] STG_PID_LINE = 12'h00A;
  localparam logic [11:0] STG_HD_ERR_LINE = 12'h001;
  // a/v delay animation length in frames and pulse centre
  localparam logic [7:0] STG_AVD_PERIOD = 8'h32;
  localparam logic [7:0] STG_AVD_CENTER = 8'h19;
  // ident box corner and size
  localparam logic [11:0] STG_IDENT_X = 12'h040;
  localparam logic [11:0] STG_IDENT_Y = 12'h020;
  localparam logic [11:0] STG_IDENT_W = 12'h100;
  localparam logic [11:0] STG_IDENT_H = 12'h040;
  localparam logic [9:0] STG_IDENT_WORD = 10'h3AC;
  localparam logic [9:0] STG_BOX_WORD = 10'h200;

  typedef enum logic [2:0] {
    STG_PAT_BARS, STG_PAT_EQ, STG_PAT_PLL, STG_PAT_CHECK,
    STG_PAT_FIELD, STG_PAT_ZONE, STG_PAT_CLIP, STG_PAT_RAMP
  } stg_pat_t;
  typedef enum logic [1:0] {STG_STD_SD, STG_STD_HD, STG_STD_3G, STG_STD_RSV} stg_std_t;
  typedef enum logic [1:0] {STG_SRC_REF, STG_SRC_VID, STG_SRC_FREE, STG_SRC_OFF} stg_src_t;
  typedef enum logic [1:0] {STG_CMD_BACK, STG_CMD_STOP, STG_CMD_FWD, STG_CMD_PLAY} stg_cmd_t;
endpackage

// File: design/stg_gen.sv
// sdi test signal generator: timing, patterns, checksums, overlays, a/v delay, clip playout
// Behaviour
// RULE1 - equalizer stress: nineteen zero bits then one one bit, repeated
// RULE2 - lock-loop stress: two ones then two zeros, repeated throughout
// RULE3 - combined stress: equalizer content upper half, lock-loop content lower half
// RULE4 - combined stress in dual-stream mode forces both streams to carry it
// RULE5 - other pattern selection cancels force, except solid field and zone plate
// RULE6 - sd checksum packet insertion switchable; hd line checksum always on
// RULE7 - sd: one packet per field, every value corrupted when errors on
// RULE8 - hd: checksum every line, only line 1 corrupted when errors on
// RULE9 - optional: corrupt only field 1 switching line, not sd packets
// RULE10 - payload id enable held separately for sd, hd and 3g
// RULE11 - ident overlay never drawn over zone plate or solid field
// RULE12 - audio pulse offset from animation by signed whole frames
// RULE13 - delay pulse insertable on any of sixteen audio channels together
// RULE14 - clip playout takes format and rate from the clip
// RULE15 - clip transport: step back, stop, step forward, looped play
// RULE16 - clip sent with its audio and payload identifier
// RULE17 - box and ident overlays off while a clip is selected
// RULE18 - equal frame rates: exact horizontal and vertical lock
// RULE19 - integer related rates: exact lock on every n-th reference frame
// RULE20 - unrelated rates: static lock, phase may differ per lock
// RULE21 - timing source: sync reference, video input or free run
// RULE22 - output timing shifted from reference by line and pixel counts
// RULE23 - corrupted checksum has its lowest bit inverted, never matching
`timescale 1ns/1ps
module stg_gen
  import stg_pkg::*;
#(
  parameter int CLK_MHZ = 250
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic ref_sync,
  input wire logic vid_sync,
  input wire logic [9:0] clip_word,
  input wire logic [11:0] clip_h_total,
  input wire logic [11:0] clip_v_total,
  input wire logic [1:0] clip_std,
  input wire logic [7:0] clip_len,
  input wire logic [9:0] clip_pid,
  input wire logic [15:0] clip_audio,
  output logic [7:0] clip_frame,
  output logic ser_a,
  output logic ser_b,
  output logic [9:0] word_a,
  output logic [15:0] audio_pulse,
  output logic [15:0] audio_out
);

  // ------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------
  if (CLK_MHZ < 1) begin : g_bad_clk
    $error("stg_gen: CLK_MHZ must be positive");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    stg_pat_t pat;
    logic forced;
    logic dual;
    stg_std_t std;
    logic edh_en;
    logic err_en;
    logic swl_mode;
    logic [2:0] pid_en;
    logic ident_en;
    logic box_en;
    stg_src_t src;
    logic related;
    logic [11:0] h_total;
    logic [11:0] v_total;
    logic [11:0] pix_off;
    logic [11:0] line_off;
    logic [7:0] avd_delay;
    logic [15:0] avd_mask;
    logic [11:0] sw_line;
    logic [9:0] pid_word;
    logic [3:0] ratio;
    logic [9:0] color;
    logic [11:0] x;
    logic [11:0] y;
    logic [7:0] fcnt;
    logic [3:0] ref_cnt;
    logic locked;
    logic [3:0] bitc;
    logic [9:0] sh;
    logic [4:0] run;
    logic [1:0] pll;
    logic [9:0] csum;
    logic [9:0] word;
    logic ser_a;
    logic ser_b;
    logic [15:0] aud;
    logic [15:0] aud_emb;
    logic [31:0] rdata;
    logic [7:0] clip_idx;
    logic clip_play;
  } stg_state_t;

  stg_state_t s;
  stg_state_t next_s;

  // ------------------------------------------------------------
  // combinational helpers
  // ------------------------------------------------------------
  logic clip_on;
  logic [11:0] h_tot;
  logic [11:0] v_tot;
  stg_std_t std_act;
  logic pix_tick;
  logic line_end;
  logic frame_end;
  logic sync_sel;
  logic [16:0] zone;
  logic [9:0] pix_word;
  logic in_ident;
  logic on_edge;
  logic sd_packet_line;
  logic csum_ins;
  logic csum_bad;
  logic pid_ins;
  logic [8:0] avd_pos;
  logic [8:0] avd_wrap;
  logic eq_bit;
  logic pll_bit;
  logic chk_bit;
  logic [1:0] std_idx;
  stg_pat_t wr_pat;

  assign clip_on = (s.pat == STG_PAT_CLIP);
  // clip playout follows the clip's own raster and standard
  assign h_tot = clip_on ? clip_h_total : s.h_total; // RULE14
  assign v_tot = clip_on ? clip_v_total : s.v_total; // RULE14
  assign std_act = clip_on ? stg_std_t'(clip_std) : s.std; // RULE14
  assign pix_tick = (s.bitc == STG_WORD_LAST);
  assign line_end = pix_tick && (s.x == h_tot - 12'h001);
  assign frame_end = line_end && (s.y == v_tot - 12'h001);
  // a source of free run never realigns the raster
  assign sync_sel = (s.src == STG_SRC_REF) ? ref_sync : ((s.src == STG_SRC_VID) ? vid_sync : 1'b0); // RULE21
  assign wr_pat = stg_pat_t'(reg_wdata[STG_CTRL_PAT +: 3]);
  assign std_idx = (std_act == STG_STD_RSV) ? 2'h2 : std_act;

  // pixel content before overlays and ancillary data
  always_comb begin
    zone = {9'h000, s.x[7:0]} * {9'h000, s.x[7:0]} + {9'h000, s.y[7:0]} * {9'h000, s.y[7:0]}
           + {9'h000, s.fcnt};
    unique case (s.pat)
      STG_PAT_BARS: pix_word = {s.x[9:7], 7'h40};
      STG_PAT_FIELD: pix_word = s.color;
      STG_PAT_ZONE: pix_word = zone[15:6];
      STG_PAT_CLIP: pix_word = clip_word;
      STG_PAT_RAMP: pix_word = s.x[9:0];
      default: pix_word = 10'h200;
    endcase
  end

  // overlays are suppressed over zone plate, solid field and clips
  assign in_ident = (s.x >= STG_IDENT_X) && (s.x < STG_IDENT_X + STG_IDENT_W)
                    && (s.y >= STG_IDENT_Y) && (s.y < STG_IDENT_Y + STG_IDENT_H);
  assign on_edge = in_ident && ((s.x == STG_IDENT_X) || (s.y == STG_IDENT_Y));

  // checksum slot is the last word of a line
  assign sd_packet_line = (s.y == STG_EDH_LINE) || (s.y == STG_EDH_LINE + (v_tot >> 1));
  always_comb begin
    if (std_act == STG_STD_SD) begin
      csum_ins = s.edh_en && sd_packet_line; // RULE6 RULE7
      csum_bad = s.err_en; // RULE7
    end else begin
      csum_ins = 1'b1; // RULE6 RULE8
      if (s.swl_mode) begin
        csum_bad = s.err_en && (s.y == s.sw_line); // RULE9
      end else begin
        csum_bad = s.err_en && (s.y == STG_HD_ERR_LINE); // RULE8
      end
    end
  end
  assign pid_ins = s.pid_en[std_idx] && (s.y == STG_PID_LINE) && (s.x == 12'h000); // RULE10

  // pulse frame = centre plus signed delay, wrapped into the animation
  assign avd_pos = {1'b0, STG_AVD_CENTER} + {s.avd_delay[7], s.avd_delay}; // RULE12
  always_comb begin
    if (avd_pos[8]) begin
      avd_wrap = avd_pos + {1'b0, STG_AVD_PERIOD};
    end else if (avd_pos >= {1'b0, STG_AVD_PERIOD}) begin
      avd_wrap = avd_pos - {1'b0, STG_AVD_PERIOD};
    end else begin
      avd_wrap = avd_pos;
    end
  end

  // stress bits run straight onto the link, no word framing
  assign eq_bit = (s.run == STG_EQ_ZEROS); // RULE1
  assign pll_bit = (s.pll < STG_PLL_RUN); // RULE2
  assign chk_bit = (s.y < (v_tot >> 1)) ? eq_bit : pll_bit; // RULE3

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.rdata = 32'h0000_0000;

    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        STG_REG_CTRL: begin
          next_s.pat = wr_pat;
          next_s.dual = reg_wdata[STG_CTRL_DUAL];
          next_s.std = stg_std_t'(reg_wdata[STG_CTRL_STD +: 2]);
          next_s.edh_en = reg_wdata[STG_CTRL_EDH];
          next_s.err_en = reg_wdata[STG_CTRL_ERR];
          next_s.swl_mode = reg_wdata[STG_CTRL_SWL];
          next_s.pid_en = reg_wdata[STG_CTRL_PID +: 3];
          next_s.ident_en = reg_wdata[STG_CTRL_IDENT];
          next_s.box_en = reg_wdata[STG_CTRL_BOX];
          next_s.related = reg_wdata[STG_CTRL_REL];
          if (stg_src_t'(reg_wdata[STG_CTRL_SRC +: 2]) != s.src) begin
            next_s.locked = 1'b0; // new source takes a fresh lock
          end
          next_s.src = stg_src_t'(reg_wdata[STG_CTRL_SRC +: 2]);
          // the force survives field and zone plate choices only
          if (wr_pat == STG_PAT_CHECK && reg_wdata[STG_CTRL_DUAL]) begin
            next_s.forced = 1'b1; // RULE4
          end else if (wr_pat != STG_PAT_FIELD && wr_pat != STG_PAT_ZONE) begin
            next_s.forced = 1'b0; // RULE5
          end
        end
        STG_REG_TIMING: begin
          next_s.h_total = reg_wdata[11:0];
          next_s.v_total = reg_wdata[27:16];
        end
        STG_REG_OFFSET: begin
          next_s.pix_off = reg_wdata[11:0]; // RULE22
          next_s.line_off = reg_wdata[27:16]; // RULE22
        end
        STG_REG_AVD: begin
          next_s.avd_delay = reg_wdata[7:0];
          next_s.avd_mask = reg_wdata[23:8]; // RULE13
        end
        STG_REG_MISC: begin
          next_s.sw_line = reg_wdata[11:0];
          next_s.pid_word = reg_wdata[21:12];
          next_s.ratio = (reg_wdata[25:22] == 4'h0) ? 4'h1 : reg_wdata[25:22];
        end
        STG_REG_COLOR: next_s.color = reg_wdata[9:0];
        default: ;
      endcase
    end

    // register reads, answered in the next cycle
    if (reg_rd) begin
      unique case (reg_addr)
        STG_REG_CTRL: next_s.rdata = {15'h0000, s.related, s.src, s.box_en, s.ident_en, s.pid_en, s.swl_mode,
                                      s.err_en, s.edh_en, s.std, s.dual, s.pat};
        STG_REG_TIMING: next_s.rdata = {4'h0, s.v_total, 4'h0, s.h_total};
        STG_REG_OFFSET: next_s.rdata = {4'h0, s.line_off, 4'h0, s.pix_off};
        STG_REG_AVD: next_s.rdata = {8'h00, s.avd_mask, s.avd_delay};
        STG_REG_CLIP: next_s.rdata = {23'h000000, s.clip_play, s.clip_idx};
        STG_REG_STATUS: next_s.rdata = {2'h0, s.forced, s.locked, s.fcnt, 8'h00, s.y};
        STG_REG_MISC: next_s.rdata = {6'h00, s.ratio, s.pid_word, s.sw_line};
        STG_REG_COLOR: next_s.rdata = {22'h000000, s.color};
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end

    // clip transport commands
    if (reg_wr && reg_addr == STG_REG_CLIP) begin
      unique case (stg_cmd_t'(reg_wdata[1:0]))
        STG_CMD_BACK: begin
          next_s.clip_play = 1'b0;
          next_s.clip_idx = (s.clip_idx == 8'h00) ? clip_len - 8'h01 : s.clip_idx - 8'h01; // RULE15
        end
        STG_CMD_STOP: next_s.clip_play = 1'b0; // RULE15
        STG_CMD_FWD: begin
          next_s.clip_play = 1'b0;
          next_s.clip_idx = (s.clip_idx + 8'h01 >= clip_len) ? 8'h00 : s.clip_idx + 8'h01; // RULE15
        end
        STG_CMD_PLAY: next_s.clip_play = 1'b1; // RULE15
      endcase
    end else if (frame_end && s.clip_play && clip_on) begin
      next_s.clip_idx = (s.clip_idx + 8'h01 >= clip_len) ? 8'h00 : s.clip_idx + 8'h01; // RULE15
    end

    // word serialiser: new word loaded on the last bit of the previous one
    next_s.bitc = pix_tick ? 4'h0 : s.bitc + 4'h1;
    next_s.sh = {1'b0, s.sh[9:1]};

    // raster counters
    if (pix_tick) begin
      if (line_end) begin
        next_s.x = 12'h000;
        next_s.y = (s.y == v_tot - 12'h001) ? 12'h000 : s.y + 12'h001;
      end else begin
        next_s.x = s.x + 12'h001;
      end
      if (frame_end) begin
        next_s.fcnt = (s.fcnt == STG_AVD_PERIOD - 8'h01) ? 8'h00 : s.fcnt + 8'h01;
      end

      // word content with ancillary data and overlays
      next_s.word = pix_word;
      if (!clip_on && !(s.pat == STG_PAT_ZONE || s.pat == STG_PAT_FIELD)) begin // RULE11 RULE17
        if (s.box_en && on_edge) begin
          next_s.word = STG_BOX_WORD;
        end else if (s.ident_en && in_ident) begin
          next_s.word = STG_IDENT_WORD;
        end
      end
      if (pid_ins) begin
        next_s.word = clip_on ? clip_pid : s.pid_word; // RULE10 RULE16
      end
      if (line_end && csum_ins) begin
        next_s.word = {s.csum[9:1], s.csum[0] ^ csum_bad}; // RULE23
        next_s.csum = 10'h000;
      end else begin
        next_s.csum = line_end ? 10'h000 : {s.csum[8:0], s.csum[9]} ^ pix_word;
      end
      next_s.sh = next_s.word;
    end

    // lock: equal rates on every reference frame, related on every n-th, unrelated once
    if (sync_sel) begin
      next_s.ref_cnt = (s.ref_cnt + 4'h1 >= s.ratio) ? 4'h0 : s.ref_cnt + 4'h1;
      if ((s.related && s.ref_cnt == 4'h0) || !s.locked) begin // RULE18 RULE19 RULE20
        next_s.x = s.pix_off; // RULE22
        next_s.y = s.line_off; // RULE22
        next_s.bitc = 4'h0;
        next_s.locked = 1'b1;
        next_s.ref_cnt = (s.ratio == 4'h1) ? 4'h0 : 4'h1;
      end
    end
    if (s.src == STG_SRC_FREE) begin
      next_s.locked = 1'b0;
    end

    // stress run counters
    next_s.run = (s.run == STG_EQ_ZEROS) ? 5'h00 : s.run + 5'h01;
    next_s.pll = s.pll + 2'h1;

    // serial outputs
    unique case (s.pat)
      STG_PAT_EQ: next_s.ser_a = eq_bit;
      STG_PAT_PLL: next_s.ser_a = pll_bit;
      STG_PAT_CHECK: next_s.ser_a = chk_bit;
      default: next_s.ser_a = s.sh[0];
    endcase
    // second stream copies the first unless the combined pattern is forced and dual-stream mode is on
    next_s.ser_b = (s.forced && s.dual) ? chk_bit : next_s.ser_a; // RULE4

    // a/v delay pulse held for its frame on the chosen channels
    next_s.aud = (s.fcnt == avd_wrap[7:0]) ? s.avd_mask : 16'h0000; // RULE12 RULE13
    next_s.aud_emb = clip_on ? clip_audio : next_s.aud; // RULE16
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.h_total <= STG_RST_H_TOTAL;
      s.v_total <= STG_RST_V_TOTAL;
      s.sw_line <= STG_RST_SW_LINE;
      s.ratio <= STG_RST_RATIO;
      s.std <= STG_STD_HD;
      s.src <= STG_SRC_FREE;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign clip_frame = s.clip_idx;
  assign ser_a = s.ser_a;
  assign ser_b = s.ser_b;
  assign word_a = s.word;
  assign audio_pulse = s.aud;
  assign audio_out = s.aud_emb;

endmodule

// File: dv/stg_gen_assertions.sv
// port-level checker of the sdi test signal generator
`timescale 1ns/1ps
module stg_gen_assertions
  import stg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [7:0] clip_len,
  input wire logic [15:0] clip_audio,
  input wire logic [7:0] clip_frame,
  input wire logic ser_a,
  input wire logic ser_b,
  input wire logic [15:0] audio_out
);
  logic [16:0] ctrl_q;
  logic forced;
  logic [6:0] quiet;
  logic [4:0] zrun;
  logic clean;
  logic eq_mode;
  logic pll_mode;
  logic clip_mode;
  // mirror of control writes; quiet waits out the serial pipeline after any write
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q <= 17'h08010;
      forced <= 1'b0;
      quiet <= 7'h00;
      zrun <= 5'h00;
    end else begin
      quiet <= reg_wr ? 7'h00 : (quiet == 7'h7F ? quiet : quiet + 7'h01);
      zrun <= ser_a ? 5'h00 : (zrun == 5'h1F ? zrun : zrun + 5'h01);
      if (reg_wr && reg_addr == STG_REG_CTRL) begin
        ctrl_q <= reg_wdata[16:0];
        if (reg_wdata[2:0] == STG_PAT_CHECK && reg_wdata[3]) begin
          forced <= 1'b1;
        end else if (reg_wdata[2:0] != STG_PAT_FIELD && reg_wdata[2:0] != STG_PAT_ZONE) begin
          forced <= 1'b0;
        end
      end
    end
  end
  // sd with no packets and no overlays leaves the raw pattern on the wire
  assign clean = quiet == 7'h7F && ctrl_q[5:4] == 2'h0 && !ctrl_q[6] && !ctrl_q[9] && ctrl_q[13:12] == 2'h0;
  assign eq_mode = clean && ctrl_q[2:0] == STG_PAT_EQ;
  assign pll_mode = clean && ctrl_q[2:0] == STG_PAT_PLL;
  assign clip_mode = quiet == 7'h7F && ctrl_q[2:0] == STG_PAT_CLIP;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_lone_one;
    ser_a ##1 !ser_a;
  endsequence
  a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside read cycle");
  a_read_unmapped: assert property (reg_rd && reg_addr[3] |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_eq_lone_one: assert property (eq_mode && $rose(ser_a) |-> s_lone_one)
    else $error("equalizer one not single");
  a_eq_zero_run: assert property (eq_mode && ser_a |-> zrun == 5'h13)
    else $error("equalizer zero run wrong");
  a_pll_rise: assert property (pll_mode && $rose(ser_a) |-> !$past(ser_a, 2) && $past(ser_a, 3))
    else $error("lock-loop zero pair wrong");
  a_pll_fall: assert property (pll_mode && $fell(ser_a) |-> $past(ser_a, 2) && !$past(ser_a, 3))
    else $error("lock-loop one pair wrong");
  a_b_copy: assert property (quiet == 7'h7F && !forced |-> ser_b == ser_a)
    else $error("stream b differs without force");
  a_status_forced: assert property (reg_rd && reg_addr == STG_REG_STATUS |=> reg_rdata[29] == forced)
    else $error("forced flag wrong");
  a_clip_audio: assert property (clip_mode |-> audio_out == $past(clip_audio))
    else $error("clip audio not passed");
  a_clip_index: assert property (clip_mode |-> clip_frame < clip_len)
    else $error("clip frame out of range");
endmodule

// File: dv/stg_sync_src.sv
// sync source model for the studio reference and video input
`timescale 1ns/1ps
module stg_sync_src (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic en_ref,
  input wire logic en_vid,
  input wire logic [15:0] period,
  output logic ref_sync,
  output logic vid_sync
);
  logic [15:0] cnt;
  // one pulse per period; low when disabled so no stale pulse escapes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt <= 16'h0000;
      ref_sync <= 1'b0;
      vid_sync <= 1'b0;
    end else begin
      cnt <= (cnt >= period - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
      ref_sync <= en_ref && cnt == 16'h0000;
      vid_sync <= en_vid && cnt == 16'h0000;
    end
  end
endmodule

// File: dv/sdi_test_signal_generator_tb.sv
// self-checking testbench of the sdi test signal generator
`timescale 1ns/1ps
module sdi_test_signal_generator_tb;
  import stg_pkg::*;
  localparam int FR = 2000;
  logic clk_sys, rst, reg_wr, reg_rd, ref_sync, vid_sync, ser_a, ser_b, en_ref, en_vid;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [9:0] clip_word, clip_pid, word_a;
  logic [11:0] clip_h_total, clip_v_total;
  logic [1:0] clip_std;
  logic [7:0] clip_len, clip_frame;
  logic [15:0] clip_audio, audio_pulse, audio_out, period;
  logic [9:0] fa [FR/10];
  logic [9:0] fb [FR/10];
  int fail_count, compares, na, nb, nd;
  stg_gen dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_sync(ref_sync), .vid_sync(vid_sync), .clip_word(clip_word),
    .clip_h_total(clip_h_total), .clip_v_total(clip_v_total), .clip_std(clip_std), .clip_len(clip_len),
    .clip_pid(clip_pid), .clip_audio(clip_audio), .clip_frame(clip_frame), .ser_a(ser_a), .ser_b(ser_b),
    .word_a(word_a), .audio_pulse(audio_pulse), .audio_out(audio_out));
  stg_sync_src far (.clk_sys(clk_sys), .rst(rst), .en_ref(en_ref), .en_vid(en_vid), .period(period),
    .ref_sync(ref_sync), .vid_sync(vid_sync));
  // 250 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask
  task automatic ones(input int n);
    na = 0;
    nb = 0;
    repeat (n) begin
      @(negedge clk_sys);
      na += int'(ser_a === 1'b1);
      nb += int'(ser_b === 1'b1);
    end
  endtask
  task automatic cap(input bit second);
    for (int i = 0; i < FR / 10; i++) begin
      if (second) fb[i] = word_a;
      else fa[i] = word_a;
      repeat (10) @(negedge clk_sys);
    end
  endtask
  // same raster position in two frames, so only the altered words differ
  task automatic frame_diff(input logic [31:0] c0, input logic [31:0] c1, input bit one_bit);
    time t0;
    wr(STG_REG_CTRL, c0);
    repeat (200) @(posedge clk_sys);
    @(negedge clk_sys);
    t0 = $time;
    cap(1'b0);
    wr(STG_REG_CTRL, c1);
    while ($time < t0 + FR * 8) @(negedge clk_sys);
    cap(1'b1);
    nd = 0;
    for (int i = 0; i < FR / 10; i++) begin
      if (fa[i] !== fb[i]) begin
        nd++;
        if (one_bit) chk({22'h0, fa[i] ^ fb[i]}, 32'h1, "corrupted bits");
      end
    end
  endtask
  task automatic sync_line(input logic [11:0] exp);
    int k;
    k = 0;
    while (ref_sync !== 1'b1 && vid_sync !== 1'b1 && k < 3 * FR) begin
      @(negedge clk_sys);
      k++;
    end
    if (k >= 3 * FR) begin
      chk(32'h0, 32'h1, "sync wait timeout");
      print_verdict();
    end
    repeat (5) @(posedge clk_sys);
    rd(STG_REG_STATUS);
    chk(d & 32'h1000_0FFF, {20'h10000, exp}, "lock line");
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(STG_REG_TIMING);
    chk(d, 32'h0465_0898, "timing reset");
    rd(STG_REG_MISC);
    chk(d & 32'h03C0_0FFF, 32'h0040_0007, "misc reset");
    wr(4'hC, 32'hFFFF_FFFF);
    rd(4'hC);
    chk(d, 32'h0, "unmapped");
    wr(STG_REG_TIMING, 32'h0014_000A);
    rd(STG_REG_TIMING);
    chk(d, 32'h0014_000A, "timing");
    wr(STG_REG_MISC, 32'h006A_5007);
    $display("test regs done");
  endtask
  task automatic t_stress;
    wr(STG_REG_CTRL, 32'h8001);
    repeat (200) @(posedge clk_sys);
    ones(100);
    chk(na, 5, "equalizer ones");
    wr(STG_REG_CTRL, 32'h8002);
    repeat (200) @(posedge clk_sys);
    ones(100);
    chk(na, 50, "lock-loop ones");
    $display("test stress done");
  endtask
  // top half equalizer (5 ones a line), bottom half lock-loop (50 a line)
  task automatic t_force;
    wr(STG_REG_CTRL, 32'h800B);
    repeat (200) @(posedge clk_sys);
    ones(FR);
    chk(na, 550, "combined a");
    chk(nb, 550, "combined b");
    wr(STG_REG_COLOR, 32'h3FF);
    wr(STG_REG_CTRL, 32'h800C);
    repeat (200) @(posedge clk_sys);
    ones(FR);
    chk(na, FR, "field a");
    chk(nb, 550, "field keeps b");
    rd(STG_REG_STATUS);
    chk({31'h0, d[29]}, 32'h1, "forced set");
    wr(STG_REG_CTRL, 32'h8008);
    repeat (200) @(posedge clk_sys);
    rd(STG_REG_STATUS);
    chk({31'h0, d[29]}, 32'h0, "forced cleared");
    $display("test force done");
  endtask
  task automatic t_crc;
    frame_diff(32'h8010, 32'h8090, 1'b1);
    chk(nd, 1, "hd errors");
    frame_diff(32'h8040, 32'h80C0, 1'b1);
    chk(nd, 2, "sd errors");
    frame_diff(32'h8010, 32'h8190, 1'b1);
    chk(nd, 1, "switch line hd");
    frame_diff(32'h8040, 32'h81C0, 1'b1);
    chk(nd, 2, "switch line sd");
    frame_diff(32'h8010, 32'h8210, 1'b0);
    chk(nd, 0, "pid other group");
    frame_diff(32'h8010, 32'h8410, 1'b0);
    chk({31'h0, nd != 0}, 32'h1, "pid hd group");
    $display("test checksum done");
  endtask
  task automatic t_lock;
    wr(STG_REG_OFFSET, 32'h0005_0000);
    wr(STG_REG_CTRL, 32'h0010);
    en_ref <= 1'b1;
    sync_line(12'h005);
    sync_line(12'h005);
    en_ref <= 1'b0;
    wr(STG_REG_OFFSET, 32'h0003_0000);
    wr(STG_REG_CTRL, 32'h4010);
    en_vid <= 1'b1;
    sync_line(12'h003);
    sync_line(12'h003);
    en_vid <= 1'b0;
    $display("test lock done");
  endtask
  task automatic t_clip;
    clip_audio <= 16'h5A3C;
    wr(STG_REG_CTRL, 32'h8006);
    wr(STG_REG_CLIP, 32'h2);
    wr(STG_REG_CLIP, 32'h2);
    wr(STG_REG_CLIP, 32'h0);
    rd(STG_REG_CLIP);
    chk(d & 32'h1FF, 32'h001, "clip steps");
    chk({24'h0, clip_frame}, 32'h1, "clip frame port");
    wr(STG_REG_CLIP, 32'h3);
    rd(STG_REG_CLIP);
    chk({31'h0, d[8]}, 32'h1, "clip playing");
    clip_audio <= 16'hC3A5;
    for (int i = 0; i < 30; i++) begin
      repeat (100) @(posedge clk_sys);
      rd(STG_REG_STATUS);
      chk({31'h0, d[11:0] < clip_v_total}, 32'h1, "clip raster");
    end
    wr(STG_REG_CLIP, 32'h2);
    rd(STG_REG_CLIP);
    chk({31'h0, d[8]}, 32'h0, "step stops play");
    wr(STG_REG_CLIP, 32'h1);
    $display("test clip done");
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, en_ref, en_vid} = 4'h0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    period = 16'(FR);
    clip_word = 10'h155;
    clip_pid = 10'h2A5;
    clip_h_total = 12'h00A;
    clip_v_total = 12'h00C;
    clip_std = 2'h0;
    clip_len = 8'h04;
    clip_audio = 16'h0000;
    fail_count = 0;
    compares = 0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_stress();
    t_force();
    t_crc();
    t_lock();
    t_clip();
    print_verdict();
  end
endmodule
bind stg_gen stg_gen_assertions u_chk (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .clip_len(clip_len),
  .clip_audio(clip_audio), .clip_frame(clip_frame), .ser_a(ser_a), .ser_b(ser_b), .audio_out(audio_out));
